// *** hw/prmc_pkg.sv ***
package prmc_pkg;

  // Register byte offsets
  localparam logic [11:0] PRMC_OFF_SYSCFG = 12'h000;
  localparam logic [11:0] PRMC_OFF_MISC   = 12'h004;
  localparam logic [11:0] PRMC_OFF_CTRL   = 12'h008;
  localparam logic [11:0] PRMC_OFF_STATUS = 12'h00C;

  // Field positions
  localparam int unsigned PRMC_VARIANT_BIT  = 5;
  localparam int unsigned PRMC_REGOFF_BIT   = 0;
  localparam int unsigned PRMC_FIRQ_EN_LSB  = 0;
  localparam int unsigned PRMC_FIRQ_POL_LSB = 8;
  localparam int unsigned PRMC_RDY_EN_BIT   = 16;
  localparam int unsigned PRMC_RDY_POL_BIT  = 17;
  localparam int unsigned PRMC_LP_DIS_BIT   = 18;
  localparam int unsigned PRMC_ST_LSB       = 0;
  localparam int unsigned PRMC_ST_LPREF_BIT = 3;
  localparam int unsigned PRMC_ST_NMI_BIT   = 4;
  localparam int unsigned PRMC_ST_RST_BIT   = 5;
  localparam int unsigned PRMC_ST_FIRQ_LSB  = 8;

  // Values after reset
  localparam logic       PRMC_VARIANT_RST  = 1'b0;
  localparam logic       PRMC_REGOFF_RST   = 1'b0;
  localparam logic [7:0] PRMC_FIRQ_EN_RST  = 8'h00;
  localparam logic [7:0] PRMC_FIRQ_POL_RST = 8'h00;
  localparam logic       PRMC_RDY_EN_RST   = 1'b0;
  localparam logic       PRMC_RDY_POL_RST  = 1'b0;
  localparam logic       PRMC_LP_DIS_RST   = 1'b0;

  // Timing
  localparam int unsigned PRMC_CLK_PERIOD_NS = 20;
  localparam int unsigned PRMC_WAKE_PULSE_NS = 40;
  localparam int unsigned PRMC_WAKE_PULSE_CYC =
    (PRMC_WAKE_PULSE_NS + PRMC_CLK_PERIOD_NS - 1) / PRMC_CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    PRMC_RUN     = 3'h0,
    PRMC_DRAIN   = 3'h1,
    PRMC_IDLE    = 3'h3,
    PRMC_PD_PROT = 3'h2,
    PRMC_PD_INT  = 3'h6
  } prmc_state_t;

  typedef enum logic [1:0]
  {
    PRMC_REQ_NONE = 2'h0,
    PRMC_REQ_IDLE = 2'h1,
    PRMC_REQ_DEEP = 2'h2
  } prmc_req_t;

endpackage

// *** hw/prmc_sync_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface prmc_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// *** hw/prmc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module prmc_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic presetn,
  input  wire logic pclk,
  input  wire logic ce,
  // Pins
  prmc_sync_if.sync pins
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] clean_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;
  logic [W-1:0] s3_nxt;
  logic [W-1:0] clean_nxt;

  always_comb
  begin
    s1_nxt    = pins.raw;
    s2_nxt    = s1_r;
    s3_nxt    = s2_r;
    // Hold while stages two and three disagree
    clean_nxt = (s2_r & s3_r) | (clean_r & (s2_r | s3_r));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      clean_r <= RST_VAL;
    end
    else if (ce)
    begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      s3_r    <= s3_nxt;
      clean_r <= clean_nxt;
    end
  end

  assign pins.clean = clean_r;
endmodule
`default_nettype wire

// *** hw/prmc_top.sv ***
// Notes on behaviour
// - Idle halts CPU, peripherals keep running
// - Any interrupt ends idle, CPU resumes
// - Pending bus transfers finish before entry
// - No entry if enabled ready missed
// - Power-down stops clock, holds watchdog
// - Low-power osc present: main osc stops
// - Detected low-power osc stays RTC reference
// - Main-only: main osc runs in power-down
// - Variant bit zero selects protected power-down
// - Protected entry needs NMI pin low
// - Protected exit only by reset pin
// - Variant bit one selects interruptible power-down
// - Interruptible entry needs enabled irqs inactive
// - Reset, fast irq, RTC, CAN, I2C wake
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module prmc_top #(
  parameter int unsigned NUM_FIRQ = 8
) (
  // Clock, reset, enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // CPU core
  input  wire logic                 idle_instruction,
  input  wire logic                 deep_sleep_instruction,
  input  wire logic                 bus_busy,
  input  wire logic                 last_access_ready_level,
  input  wire logic                 any_irq_request,
  // Wake sources on this clock
  input  wire logic                 rtc_irq,
  input  wire logic                 can_irq,
  input  wire logic                 i2c_irq,
  // Pins
  input  wire logic                 reset_input_pin_n,
  input  wire logic                 nmi_pin_n,
  input  wire logic [NUM_FIRQ-1:0]  fast_external_irq_pin,
  input  wire logic                 low_power_osc_running,
  // Power control
  output logic                      cpu_halt,
  output logic                      periph_clk_en,
  output logic                      core_clk_en,
  output logic                      wdt_hold,
  output logic                      main_osc_en,
  output logic                      rtc_ref_low_power,
  output logic                      regulator_off,
  output logic                      idle_wake,
  output logic                      entry_refused,
  output prmc_pkg::prmc_state_t     mode_state
);
  import prmc_pkg::*;

  localparam int unsigned SW = NUM_FIRQ + 3;

  generate
    if (NUM_FIRQ < 1 || NUM_FIRQ > 8)
    begin : g_bad_firq
      $error("NUM_FIRQ must be 1 to 8");
    end
    if (PRMC_WAKE_PULSE_CYC < 2)
    begin : g_bad_pulse
      $error("Wake pulse too short for pin filter");
    end
  endgenerate

  function automatic logic [31:0] prmc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    prmc_merge = (old_v & ~m) | (new_v & m);
  endfunction

  // Pin filter: three stages, change once two and three agree
  prmc_sync_if #(.W(SW)) pin_if ();
  assign pin_if.raw = {reset_input_pin_n, nmi_pin_n, fast_external_irq_pin,
                       low_power_osc_running};

  prmc_sync #(
    .W       (SW),
    .RST_VAL ({2'b11, {(NUM_FIRQ + 1){1'b0}}})
  ) u_sync (
    .presetn (presetn),
    .pclk    (pclk),
    .ce      (ce),
    .pins    (pin_if.sync)
  );

  logic                rst_pin_n_c;
  logic                nmi_n_c;
  logic [NUM_FIRQ-1:0] firq_c;
  logic                lp_run_c;
  assign rst_pin_n_c = pin_if.clean[SW-1];
  assign nmi_n_c     = pin_if.clean[SW-2];
  assign firq_c      = pin_if.clean[NUM_FIRQ:1];
  assign lp_run_c    = pin_if.clean[0];

  // Register state
  logic                variant_r;
  logic                regoff_r;
  logic [NUM_FIRQ-1:0] firq_en_r;
  logic [NUM_FIRQ-1:0] firq_pol_r;
  logic                rdy_en_r;
  logic                rdy_pol_r;
  logic                lp_dis_r;
  logic                lp_ref_r;
  logic                variant_nxt;
  logic                regoff_nxt;
  logic [NUM_FIRQ-1:0] firq_en_nxt;
  logic [NUM_FIRQ-1:0] firq_pol_nxt;
  logic                rdy_en_nxt;
  logic                rdy_pol_nxt;
  logic                lp_dis_nxt;
  logic                lp_ref_nxt;

  // APB state
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;

  logic [31:0] sys_word;
  logic [31:0] misc_word;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic [31:0] ctrl_new;
  logic [31:0] sys_new;
  logic [31:0] misc_new;
  logic        mapped;
  logic        access;
  logic        wr_fire;

  prmc_state_t st_r;
  prmc_state_t st_nxt;
  prmc_req_t   req_r;
  prmc_req_t   req_nxt;

  always_comb
  begin
    sys_word = 32'h0000_0000;
    sys_word[PRMC_VARIANT_BIT] = variant_r;
    misc_word = 32'h0000_0000;
    misc_word[PRMC_REGOFF_BIT] = regoff_r;
    ctrl_word = 32'h0000_0000;
    ctrl_word[PRMC_FIRQ_EN_LSB +: NUM_FIRQ]  = firq_en_r;
    ctrl_word[PRMC_FIRQ_POL_LSB +: NUM_FIRQ] = firq_pol_r;
    ctrl_word[PRMC_RDY_EN_BIT]  = rdy_en_r;
    ctrl_word[PRMC_RDY_POL_BIT] = rdy_pol_r;
    ctrl_word[PRMC_LP_DIS_BIT]  = lp_dis_r;
    stat_word = 32'h0000_0000;
    stat_word[PRMC_ST_LSB +: 3]  = st_r;
    stat_word[PRMC_ST_LPREF_BIT] = lp_ref_r;
    stat_word[PRMC_ST_NMI_BIT]   = nmi_n_c;
    stat_word[PRMC_ST_RST_BIT]   = rst_pin_n_c;
    stat_word[PRMC_ST_FIRQ_LSB +: NUM_FIRQ] = firq_c;
  end

  // Address decode
  always_comb
  begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr == PRMC_OFF_SYSCFG)
      rd_word = sys_word;
    else if (paddr == PRMC_OFF_MISC)
      rd_word = misc_word;
    else if (paddr == PRMC_OFF_CTRL)
      rd_word = ctrl_word;
    else if (paddr == PRMC_OFF_STATUS)
      rd_word = stat_word;
    else
      mapped = 1'b0;
  end

  // One wait state; write lands on the edge that sees pready
  always_comb
  begin
    access      = psel & penable & ~pready_r;
    wr_fire     = psel & penable & pready_r & pwrite & ~pslverr_r;
    pready_nxt  = access;
    pslverr_nxt = access & ~mapped;
    prdata_nxt  = (access & ~pwrite) ? rd_word : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (ce)
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Software registers and oscillator reference
  always_comb
  begin
    variant_nxt  = variant_r;
    regoff_nxt   = regoff_r;
    firq_en_nxt  = firq_en_r;
    firq_pol_nxt = firq_pol_r;
    rdy_en_nxt   = rdy_en_r;
    rdy_pol_nxt  = rdy_pol_r;
    lp_dis_nxt   = lp_dis_r;
    ctrl_new     = prmc_merge(ctrl_word, pwdata, pstrb);
    sys_new      = prmc_merge(sys_word, pwdata, pstrb);
    misc_new     = prmc_merge(misc_word, pwdata, pstrb);
    if (wr_fire && paddr == PRMC_OFF_SYSCFG)
      variant_nxt = sys_new[PRMC_VARIANT_BIT];
    if (wr_fire && paddr == PRMC_OFF_MISC)
      regoff_nxt = misc_new[PRMC_REGOFF_BIT];
    if (wr_fire && paddr == PRMC_OFF_CTRL)
    begin
      firq_en_nxt  = ctrl_new[PRMC_FIRQ_EN_LSB +: NUM_FIRQ];
      firq_pol_nxt = ctrl_new[PRMC_FIRQ_POL_LSB +: NUM_FIRQ];
      rdy_en_nxt   = ctrl_new[PRMC_RDY_EN_BIT];
      rdy_pol_nxt  = ctrl_new[PRMC_RDY_POL_BIT];
      lp_dis_nxt   = ctrl_new[PRMC_LP_DIS_BIT];
    end
    // Once seen, kept even if the oscillator later looks stopped
    if (lp_dis_r)
      lp_ref_nxt = 1'b0;
    else
      lp_ref_nxt = lp_ref_r | lp_run_c;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      variant_r  <= PRMC_VARIANT_RST;
      regoff_r   <= PRMC_REGOFF_RST;
      firq_en_r  <= PRMC_FIRQ_EN_RST[NUM_FIRQ-1:0];
      firq_pol_r <= PRMC_FIRQ_POL_RST[NUM_FIRQ-1:0];
      rdy_en_r   <= PRMC_RDY_EN_RST;
      rdy_pol_r  <= PRMC_RDY_POL_RST;
      lp_dis_r   <= PRMC_LP_DIS_RST;
      lp_ref_r   <= 1'b0;
    end
    else if (ce)
    begin
      variant_r  <= variant_nxt;
      regoff_r   <= regoff_nxt;
      firq_en_r  <= firq_en_nxt;
      firq_pol_r <= firq_pol_nxt;
      rdy_en_r   <= rdy_en_nxt;
      rdy_pol_r  <= rdy_pol_nxt;
      lp_dis_r   <= lp_dis_nxt;
      lp_ref_r   <= lp_ref_nxt;
    end
  end

  // Mode sequencer
  logic                ready_ok;
  logic                firq_hit;
  logic                wake_nxt;
  logic                refuse_nxt;
  logic [NUM_FIRQ-1:0] firq_act;

  always_comb
  begin
    firq_act   = firq_en_r & ~(firq_c ^ firq_pol_r);
    firq_hit   = |firq_act;
    ready_ok   = ~rdy_en_r | (last_access_ready_level == rdy_pol_r);
    st_nxt     = st_r;
    req_nxt    = req_r;
    wake_nxt   = 1'b0;
    refuse_nxt = 1'b0;
    case (st_r)
      PRMC_RUN:
      begin
        if (idle_instruction || deep_sleep_instruction)
        begin
          if (!ready_ok)
            refuse_nxt = 1'b1;
          else
          begin
            st_nxt  = PRMC_DRAIN;
            req_nxt = deep_sleep_instruction ? PRMC_REQ_DEEP : PRMC_REQ_IDLE;
          end
        end
      end
      PRMC_DRAIN:
      begin
        // Last access may be the drained one, so ready is checked again
        if (!bus_busy)
        begin
          st_nxt  = PRMC_RUN;
          req_nxt = PRMC_REQ_NONE;
          if (!ready_ok)
            refuse_nxt = 1'b1;
          else if (req_r == PRMC_REQ_IDLE)
            st_nxt = PRMC_IDLE;
          else if (!variant_r)
          begin
            if (!nmi_n_c)
              st_nxt = PRMC_PD_PROT;
            else
              refuse_nxt = 1'b1;
          end
          else if (firq_hit)
            refuse_nxt = 1'b1;
          else
            st_nxt = PRMC_PD_INT;
        end
      end
      PRMC_IDLE:
      begin
        if (any_irq_request || !rst_pin_n_c)
        begin
          st_nxt   = PRMC_RUN;
          wake_nxt = 1'b1;
        end
      end
      PRMC_PD_PROT:
      begin
        if (!rst_pin_n_c)
          st_nxt = PRMC_RUN;
      end
      PRMC_PD_INT:
      begin
        // Filtered pin needs two agreeing samples, a 40 ns pulse gives them
        if (!rst_pin_n_c || firq_hit || rtc_irq || can_irq || i2c_irq)
          st_nxt = PRMC_RUN;
      end
      default:
      begin
        st_nxt  = PRMC_RUN;
        req_nxt = PRMC_REQ_NONE;
      end
    endcase
  end

  // Outputs follow the next state so they are registered
  logic pd_nxt;
  logic halt_nxt;
  logic main_osc_nxt;
  logic regoff_out_nxt;
  logic cpu_halt_r;
  logic periph_clk_en_r;
  logic core_clk_en_r;
  logic wdt_hold_r;
  logic main_osc_en_r;
  logic rtc_ref_lp_r;
  logic regulator_off_r;
  logic idle_wake_r;
  logic entry_refused_r;

  always_comb
  begin
    pd_nxt         = (st_nxt == PRMC_PD_PROT) || (st_nxt == PRMC_PD_INT);
    halt_nxt       = pd_nxt || (st_nxt == PRMC_IDLE);
    main_osc_nxt   = ~(pd_nxt & lp_ref_nxt);
    regoff_out_nxt = pd_nxt & regoff_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r            <= PRMC_RUN;
      req_r           <= PRMC_REQ_NONE;
      cpu_halt_r      <= 1'b0;
      periph_clk_en_r <= 1'b1;
      core_clk_en_r   <= 1'b1;
      wdt_hold_r      <= 1'b0;
      main_osc_en_r   <= 1'b1;
      rtc_ref_lp_r    <= 1'b0;
      regulator_off_r <= 1'b0;
      idle_wake_r     <= 1'b0;
      entry_refused_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r            <= st_nxt;
      req_r           <= req_nxt;
      cpu_halt_r      <= halt_nxt;
      periph_clk_en_r <= ~pd_nxt;
      core_clk_en_r   <= ~pd_nxt;
      wdt_hold_r      <= pd_nxt;
      main_osc_en_r   <= main_osc_nxt;
      rtc_ref_lp_r    <= lp_ref_nxt;
      regulator_off_r <= regoff_out_nxt;
      idle_wake_r     <= wake_nxt;
      entry_refused_r <= refuse_nxt;
    end
  end

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign cpu_halt          = cpu_halt_r;
  assign periph_clk_en     = periph_clk_en_r;
  assign core_clk_en       = core_clk_en_r;
  assign wdt_hold          = wdt_hold_r;
  assign main_osc_en       = main_osc_en_r;
  assign rtc_ref_low_power = rtc_ref_lp_r;
  assign regulator_off     = regulator_off_r;
  assign idle_wake         = idle_wake_r;
  assign entry_refused     = entry_refused_r;
  assign mode_state        = st_r;
endmodule
`default_nettype wire

// *** test/prmc_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module prmc_cpu_model (
  // Clock
  input  wire logic       pclk,
  // Core side
  output var  logic       idle_instruction,
  output var  logic       deep_sleep_instruction,
  output var  logic       bus_busy,
  output var  logic       last_access_ready_level,
  // Pins
  output var  logic       reset_input_pin_n,
  output var  logic       nmi_pin_n,
  output var  logic [7:0] fast_external_irq_pin
);
  initial
  begin
    {idle_instruction, deep_sleep_instruction, bus_busy} = 3'h0;
    last_access_ready_level = 1'b0;
    {reset_input_pin_n, nmi_pin_n} = 2'h3;
    fast_external_irq_pin = 8'h00;
  end
  // Entry instruction, then the bus transfer it left pending
  task automatic issue(input logic deep, input int busy, input logic lvl);
    @(posedge pclk);
    idle_instruction        <= !deep;
    deep_sleep_instruction  <= deep;
    bus_busy                <= (busy > 0);
    last_access_ready_level <= lvl;
    @(posedge pclk);
    idle_instruction        <= 1'b0;
    deep_sleep_instruction  <= 1'b0;
    repeat (busy) @(posedge pclk);
    bus_busy                <= 1'b0;
  endtask
  task automatic set_pins(input logic nmi_n, input logic [7:0] firq);
    @(posedge pclk);
    nmi_pin_n             <= nmi_n;
    fast_external_irq_pin <= firq;
  endtask
  // Caller keeps cyc at the wake minimum or above; shorter may be filtered out
  task automatic pulse_pins(input logic rst_n, input logic [7:0] firq, input int cyc);
    logic [7:0] old;
    old = fast_external_irq_pin;
    @(posedge pclk);
    reset_input_pin_n     <= rst_n;
    fast_external_irq_pin <= firq;
    repeat (cyc) @(posedge pclk);
    reset_input_pin_n     <= 1'b1;
    fast_external_irq_pin <= old;
  endtask
endmodule
`default_nettype wire

// *** test/prmc_top_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module prmc_top_sva (
  // Clock, reset, APB
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pready,
  // Requests and pins
  input  wire logic             bus_busy,
  input  wire logic             any_irq_request,
  input  wire logic             rtc_irq,
  input  wire logic             can_irq,
  input  wire logic             i2c_irq,
  input  wire logic             reset_input_pin_n,
  input  wire logic             nmi_pin_n,
  // Power control
  input  wire logic             cpu_halt,
  input  wire logic             periph_clk_en,
  input  wire logic             core_clk_en,
  input  wire logic             wdt_hold,
  input  wire logic             main_osc_en,
  input  wire logic             rtc_ref_low_power,
  input  wire logic             idle_wake,
  input  wire logic             entry_refused,
  input  var  prmc_pkg::prmc_state_t mode_state
);
  import prmc_pkg::*;
  logic in_pd;
  assign in_pd = (mode_state == PRMC_PD_PROT) || (mode_state == PRMC_PD_INT);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_halt_modes: assert property (cpu_halt == (in_pd || mode_state == PRMC_IDLE))
    else $error("cpu_halt does not follow the mode");
  a_pd_frozen: assert property (in_pd |-> !core_clk_en && !periph_clk_en && wdt_hold)
    else $error("clocks not stopped in power-down");
  a_drain_wait: assert property (mode_state == PRMC_DRAIN && bus_busy
    |=> mode_state == PRMC_DRAIN)
    else $error("left drain with bus busy");
  a_osc_choice: assert property (main_osc_en == !(in_pd && rtc_ref_low_power))
    else $error("main oscillator enable wrong");
  a_refuse_run: assert property (entry_refused |-> mode_state == PRMC_RUN
    && ($past(mode_state) == PRMC_RUN || $past(mode_state) == PRMC_DRAIN))
    else $error("refusal outside entry");
  a_prot_nmi: assert property (mode_state == PRMC_PD_PROT
    && $past(mode_state) == PRMC_DRAIN |-> !$past(nmi_pin_n, 3))
    else $error("protected entry without nmi low");
  a_prot_hold: assert property (reset_input_pin_n [*5] ##0 mode_state == PRMC_PD_PROT
    |=> mode_state == PRMC_PD_PROT)
    else $error("protected power-down left without reset pin");
  a_int_wake: assert property (mode_state == PRMC_PD_INT
    && (rtc_irq || can_irq || i2c_irq) |=> mode_state == PRMC_RUN)
    else $error("interruptible power-down not woken");
  a_idle_wake: assert property (mode_state == PRMC_IDLE && any_irq_request
    |=> mode_state == PRMC_RUN && idle_wake)
    else $error("idle not ended by interrupt");
  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  c_idle: cover property (mode_state == PRMC_IDLE && any_irq_request);
  c_prot: cover property (mode_state == PRMC_PD_PROT ##1 mode_state == PRMC_RUN);
  c_refused: cover property (entry_refused);
endmodule
bind prmc_top prmc_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .bus_busy,
  .any_irq_request, .rtc_irq, .can_irq, .i2c_irq, .reset_input_pin_n, .nmi_pin_n, .cpu_halt,
  .periph_clk_en, .core_clk_en, .wdt_hold, .main_osc_en, .rtc_ref_low_power, .idle_wake,
  .entry_refused, .mode_state);
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import prmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        idle_instruction, deep_sleep_instruction, bus_busy, last_access_ready_level;
  logic        any_irq_request, rtc_irq, can_irq, i2c_irq, low_power_osc_running;
  logic        reset_input_pin_n, nmi_pin_n;
  logic [7:0]  fast_external_irq_pin, en, pol, pin, act;
  logic        cpu_halt, periph_clk_en, core_clk_en, wdt_hold, main_osc_en;
  logic        rtc_ref_low_power, regulator_off, idle_wake, entry_refused;
  logic        e, refused_seen, lp_exp, deep, var1, nmi_lo, rdy_en, rdy_pol, lvl, regoff;
  prmc_state_t mode_state, exp;
  int          n_fail, checked, busy, k;

  prmc_top DUT (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .idle_instruction, .deep_sleep_instruction,
    .bus_busy, .last_access_ready_level, .any_irq_request, .rtc_irq, .can_irq, .i2c_irq,
    .reset_input_pin_n, .nmi_pin_n, .fast_external_irq_pin, .low_power_osc_running,
    .cpu_halt, .periph_clk_en, .core_clk_en, .wdt_hold, .main_osc_en, .rtc_ref_low_power,
    .regulator_off, .idle_wake, .entry_refused, .mode_state);
  prmc_cpu_model cpu (.pclk, .idle_instruction, .deep_sleep_instruction, .bus_busy,
    .last_access_ready_level, .reset_input_pin_n, .nmi_pin_n, .fast_external_irq_pin);

  always #(PRMC_CLK_PERIOD_NS / 2) pclk = ~pclk;
  // Refusal is a one-cycle pulse, so latch it
  always @(posedge pclk) if (entry_refused === 1'b1) refused_seen <= 1'b1;

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] ex);
    checked++;
    if (got !== ex)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // No local limit: only the watchdog ends a hung transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (mode_state !== PRMC_RUN && n < 12)
    begin
      @(posedge pclk);
      #1 n++;
    end
  endtask
  function automatic prmc_state_t exp_mode(input logic dp, v1, nl, fa, ok);
    if (!ok) return PRMC_RUN;
    if (!dp) return PRMC_IDLE;
    if (!v1) return nl ? PRMC_PD_PROT : PRMC_RUN;
    return fa ? PRMC_RUN : PRMC_PD_INT;
  endfunction

  initial
  begin
    #1000000;
    n_fail++;
    results();
  end
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    {any_irq_request, rtc_irq, can_irq, i2c_irq, low_power_osc_running} = 5'h00;
    refused_seen = 0; lp_exp = 0; n_fail = 0; checked = 0;
    void'($urandom(6));
    repeat (2) @(posedge pclk);
    #1 check("reset outputs", {cpu_halt, main_osc_en, mode_state}, 5'h08);
    @(posedge pclk) presetn <= 1'b1;
    apb(0, PRMC_OFF_SYSCFG, 32'h0); check("syscfg reset", q, 32'h0);
    apb(0, PRMC_OFF_CTRL, 32'h0); check("ctrl reset", q, 32'h0);
    apb(1, PRMC_OFF_SYSCFG, 32'hFFFFFFFF); apb(0, PRMC_OFF_SYSCFG, 32'h0);
    check("syscfg bits", q, 32'h20);
    apb(1, 12'h010, 32'hFFFFFFFF); check("unmapped error", e, 1'h1);
    apb(0, 12'h010, 32'h0);
    check("unmapped data", q, 32'h0);
    check("unmapped read error", e, 1'h1);
    $display("register test done");
    // First four trials are fixed corners: idle, protected, interruptible, nmi refusal
    for (int i = 0; i < 40; i++)
    begin
      deep = (i < 4) ? (i != 0) : 1'($urandom);
      var1 = (i < 4) ? (i == 2) : 1'($urandom);
      nmi_lo = (i < 4) ? (i != 3) : 1'($urandom);
      {rdy_en, rdy_pol, en, pol, pin} = 26'($urandom);
      lvl = (i < 4) ? rdy_pol : 1'($urandom);
      if (i < 4) pin = ~pol;
      busy = (i < 4) ? 4 : $urandom_range(0, 3);
      regoff = (i < 4) | 1'($urandom);
      act = (pin & ~en) | (pol & en);
      if (i == 20) {low_power_osc_running, lp_exp} = 2'h3;
      if (i == 24) low_power_osc_running = 1'b0;
      apb(1, PRMC_OFF_SYSCFG, {26'h0, var1, 5'h0});
      apb(1, PRMC_OFF_MISC, {31'h0, regoff});
      apb(1, PRMC_OFF_CTRL, {14'h0, rdy_pol, rdy_en, pol, en});
      cpu.set_pins(!nmi_lo, pin);
      repeat (6) @(posedge pclk);
      #1 refused_seen = 0;
      check("lp reference", rtc_ref_low_power, lp_exp);
      exp = exp_mode(deep, var1, nmi_lo, |(en & ~(pin ^ pol)), !rdy_en || lvl == rdy_pol);
      cpu.issue(deep, busy, lvl);
      repeat (3) @(posedge pclk);
      #1 check("mode", mode_state, exp);
      check("refused", refused_seen, exp == PRMC_RUN);
      if (exp == PRMC_IDLE)
      begin
        check("idle clocks", {cpu_halt, periph_clk_en}, 2'h3);
        @(posedge pclk) any_irq_request <= 1'b1;
        @(posedge pclk) any_irq_request <= 1'b0;
        #1 check("idle wake", {mode_state, idle_wake}, {PRMC_RUN, 1'b1});
      end
      else if (exp != PRMC_RUN)
      begin
        check("pd clocks", {cpu_halt, core_clk_en, periph_clk_en, wdt_hold}, 4'h9);
        check("pd osc", {main_osc_en, regulator_off}, {!lp_exp, regoff});
        if (exp == PRMC_PD_PROT)
        begin
          @(posedge pclk) rtc_irq <= 1'b1;
          @(posedge pclk) rtc_irq <= 1'b0;
          cpu.pulse_pins(1'b1, act, 3);
          repeat (6) @(posedge pclk);
          #1 check("prot hold", mode_state, PRMC_PD_PROT);
        end
        k = (exp == PRMC_PD_PROT || (i % 5 == 3 && en == 8'h00)) ? 4 : i % 5;
        if (k < 3)
        begin
          @(posedge pclk) {i2c_irq, can_irq, rtc_irq} <= 3'(1 << k);
          @(posedge pclk) {i2c_irq, can_irq, rtc_irq} <= 3'h0;
          #1 check("int wake", mode_state, PRMC_RUN);
        end
        else
        begin
          cpu.pulse_pins(k == 3, (k == 3) ? act : pin, (k == 3) ? PRMC_WAKE_PULSE_CYC : 8);
          wait_run();
          check("pin wake", mode_state, PRMC_RUN);
        end
      end
      $display("trial %0d done", i);
    end
    apb(1, PRMC_OFF_CTRL, 32'h40000);
    repeat (2) @(posedge pclk);
    #1 check("lp disable", rtc_ref_low_power, 1'h0);
    results();
  end
endmodule
`default_nettype wire
